// ==== design/afe_ctrl_pkg.sv ====
// Purpose: constants and carrier types for the analog front end control bank
// Assumes: byte-wide registers reached by a plain strobe port at printed offsets
// Notes: every offset, field position, reset value and width lives here
package afe_ctrl_pkg;

   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam int AFE_ADDR_W = 16;
   localparam int AFE_DATA_W = 8;
   localparam int AFE_IDX_W = 5;
   localparam int AFE_NUM_REGS = 17;
   localparam int AFE_NUM_AUX = 14;
   localparam logic [AFE_ADDR_W-1:0] AFE_BASE_ADDR = 16'h2858;
   localparam logic [AFE_ADDR_W-1:0] AFE_LAST_ADDR = 16'h2868;
   localparam logic [AFE_ADDR_W-1:0] AFE_GAIN_ADDR = 16'h2858;
   localparam logic [AFE_ADDR_W-1:0] AFE_BIAS_ADDR = 16'h2859;
   localparam logic [AFE_ADDR_W-1:0] AFE_MOD_ADDR = 16'h285a;
   localparam int AFE_GAIN_IDX = 0;
   localparam int AFE_BIAS_IDX = 1;
   localparam int AFE_MOD_IDX = 2;
   localparam int AFE_AUX_IDX = 3;
   localparam logic [AFE_DATA_W-1:0] AFE_REG_RESET = 8'h00;
   localparam logic [AFE_DATA_W-1:0] AFE_RD_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int AFE_VGAIN_BIT = 6;
   localparam int AFE_BGAIN_LSB = 3;
   localparam int AFE_AGAIN_LSB = 0;
   localparam int AFE_BIAS2_LSB = 2;
   localparam int AFE_BIAS1_LSB = 0;
   localparam int AFE_AMPBIAS_BIT = 4;
   localparam int AFE_CLR_LSB = 0;
   localparam int AFE_CLR_W = 4;

   // gain as a power of two: x1, x4, x8, x16, x32
   localparam logic [2:0] AFE_LOG2_X1 = 3'h0;
   localparam logic [2:0] AFE_LOG2_X4 = 3'h2;
   localparam logic [2:0] AFE_LOG2_X8 = 3'h3;
   localparam logic [2:0] AFE_LOG2_X16 = 3'h4;
   localparam logic [2:0] AFE_LOG2_X32 = 3'h5;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [AFE_ADDR_W-1:0] addr;
      logic [AFE_DATA_W-1:0] wdata;
   } afe_bus_req_t;

   typedef struct packed {
      logic voltage_pga_gain;
      logic [2:0] current_b_pga_gain;
      logic [2:0] current_a_pga_gain;
      logic [2:0] current_b_gain_log2;
      logic [2:0] current_a_gain_log2;
      logic [1:0] second_stage_bias_trim;
      logic [1:0] first_stage_bias_trim;
      logic voltage_amp_bias_select;
      logic spare_channel_integrator_clear;
      logic voltage_integrator_clear;
      logic current_b_integrator_clear;
      logic current_a_integrator_clear;
   } afe_ctrl_t;

   typedef struct packed {
      logic [AFE_NUM_REGS-1:0][AFE_DATA_W-1:0] words;
      logic [AFE_DATA_W-1:0] rdata;
   } afe_mem_state_t;

   typedef struct packed {
      logic rd_hit;
   } afe_top_state_t;

   // codes from 100 upward all saturate at x32
   function automatic logic [2:0] afe_gain_log2(input logic [2:0] code);
      logic [2:0] g;
      g = AFE_LOG2_X32;
      if (code == 3'h0)
         g = AFE_LOG2_X1;
      else if (code == 3'h1)
         g = AFE_LOG2_X4;
      else if (code == 3'h2)
         g = AFE_LOG2_X8;
      else if (code == 3'h3)
         g = AFE_LOG2_X16;
      return g;
   endfunction

endpackage

// ==== design/afe_ctrl_mem.sv ====
// Purpose: byte storage for the analog control bank with a registered read port
// Assumes: read index is always in range; caller filters the address
// Notes: all words are also presented flat so the front end sees static levels
`timescale 1ns/1ps
module afe_ctrl_mem
   import afe_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clr,
   input wire logic we,
   input wire logic [AFE_IDX_W-1:0] widx,
   input wire logic [AFE_DATA_W-1:0] wdata,
   input wire logic rd,
   input wire logic [AFE_IDX_W-1:0] ridx,
   output logic [AFE_DATA_W-1:0] rdata,
   output logic [AFE_NUM_REGS-1:0][AFE_DATA_W-1:0] words
);

   afe_mem_state_t st_r;
   afe_mem_state_t st_nxt;
   logic [AFE_NUM_REGS-1:0][AFE_DATA_W-1:0] word_nxt;

   // ----------------------------------------------------------------
   // per-entry next value
   // ----------------------------------------------------------------
   // a bank clear outranks a write landing in the same cycle
   for (genvar i = 0; i < AFE_NUM_REGS; i++)
   begin : g_word
      assign word_nxt[i] = clr ? AFE_REG_RESET :
                           (we && widx == AFE_IDX_W'(i)) ? wdata : st_r.words[i];
   end

   // read word is captured, then held until the next read
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.words = word_nxt;
      if (rd)
         st_nxt.rdata = st_r.words[ridx];
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign rdata = st_r.rdata;
   assign words = st_r.words;

endmodule

// ==== design/afe_ctrl_regs.sv ====
// Purpose: analog front end control register bank, 0x2858 to 0x2868
// Assumes: synchronous strobes; one clock ref_clk at 125 MHz
// Notes: extra reset sources clear the bank synchronously, rst_n asynchronously
//
// Functional notes
// - bank spans 0x2858..0x2868, every register readable and writable
// - power-on, brown-out, reset pin or watchdog reset restore all defaults
// - voltage gain bit 6: clear x1, set x2; software keeps x1
// - channel B gain bits 5:3: x1, x4, x8, x16, then x32 from 100
// - channel A gain bits 2:0 use the same encoding as channel B
// - bias fields 3:2 and 1:0 scale ADC bias x1, x1.33, x2, x2.67
// - voltage amplifier bias bit 4: clear x1, set x0.67
// - integrator clear bits 3..0: spare, voltage, current B, current A
`timescale 1ns/1ps
module afe_ctrl_regs
   import afe_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic brownout_reset,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_reset,
   input wire afe_bus_req_t req,
   output logic [AFE_DATA_W-1:0] rd_data,
   output afe_ctrl_t ctrl,
   output logic [AFE_NUM_AUX-1:0][AFE_DATA_W-1:0] aux_regs
);

   afe_top_state_t st_r;
   afe_top_state_t st_nxt;
   logic in_range;
   logic bank_clr;
   logic [AFE_IDX_W-1:0] idx;
   logic [AFE_DATA_W-1:0] mem_q;
   logic [AFE_NUM_REGS-1:0][AFE_DATA_W-1:0] words;
   logic [AFE_DATA_W-1:0] gain_w;
   logic [AFE_DATA_W-1:0] bias_w;
   logic [AFE_DATA_W-1:0] mod_w;

   // ----------------------------------------------------------------
   // reset sources and address decode
   // ----------------------------------------------------------------
   // extra sources arrive synchronous, so they clear on the clock, not async
   assign bank_clr = brownout_reset | ~external_reset_pin_n | watchdog_reset;
   assign idx = AFE_IDX_W'(req.addr - AFE_BASE_ADDR);

   // whole span decodes; anything outside reads zero and ignores writes
   always_comb
   begin
      if (req.addr >= AFE_BASE_ADDR && req.addr <= AFE_LAST_ADDR)
         in_range = 1'b1;
      else
         in_range = 1'b0;
   end

   // remember whether the pending read hit the bank
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rd_hit = req.rd & in_range;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   afe_ctrl_mem u_mem (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clr(bank_clr),
      .we(req.wr & in_range),
      .widx(idx),
      .wdata(req.wdata),
      .rd(req.rd & in_range),
      .ridx(idx),
      .rdata(mem_q),
      .words(words)
   );

   assign rd_data = st_r.rd_hit ? mem_q : AFE_RD_UNMAPPED;

   // ----------------------------------------------------------------
   // front end levels
   // ----------------------------------------------------------------
   // fields come straight off the flops, so they move on the write edge
   assign gain_w = words[AFE_GAIN_IDX];
   assign bias_w = words[AFE_BIAS_IDX];
   assign mod_w = words[AFE_MOD_IDX];

   always_comb
   begin
      ctrl.voltage_pga_gain = gain_w[AFE_VGAIN_BIT];
      ctrl.current_b_pga_gain = gain_w[AFE_BGAIN_LSB +: 3];
      ctrl.current_a_pga_gain = gain_w[AFE_AGAIN_LSB +: 3];
      ctrl.current_b_gain_log2 = afe_gain_log2(gain_w[AFE_BGAIN_LSB +: 3]);
      ctrl.current_a_gain_log2 = afe_gain_log2(gain_w[AFE_AGAIN_LSB +: 3]);
      ctrl.second_stage_bias_trim = bias_w[AFE_BIAS2_LSB +: 2];
      ctrl.first_stage_bias_trim = bias_w[AFE_BIAS1_LSB +: 2];
      ctrl.voltage_amp_bias_select = mod_w[AFE_AMPBIAS_BIT];
      // no self-clear: the integrator stays held while its bit is one
      {ctrl.spare_channel_integrator_clear, ctrl.voltage_integrator_clear,
       ctrl.current_b_integrator_clear,
       ctrl.current_a_integrator_clear} = mod_w[AFE_CLR_LSB +: AFE_CLR_W];
   end

   assign aux_regs = words[AFE_NUM_REGS-1:AFE_AUX_IDX];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_write_hit;
      req.wr && in_range && !bank_clr;
   endsequence

   sequence s_read_same;
      req.rd && req.addr == $past(req.addr) && !bank_clr;
   endsequence

   a_write_read_back: assert property (
      (s_write_hit ##1 s_read_same) |=> rd_data == $past(req.wdata, 2))
      else $error("read back differs from written byte");

   a_unmapped_read_zero: assert property (
      req.rd && !in_range |=> rd_data == AFE_RD_UNMAPPED)
      else $error("unmapped read not zero");

   a_bank_clear_all: assert property (
      bank_clr |=> ctrl == '0 && aux_regs == '0)
      else $error("bank not at defaults after reset source");

   a_volt_gain_write: assert property (
      s_write_hit and req.addr == AFE_GAIN_ADDR
      |=> ctrl.voltage_pga_gain == $past(req.wdata[AFE_VGAIN_BIT]))
      else $error("voltage gain bit not taken from write");

   a_gain_b_saturate: assert property (
      ctrl.current_b_pga_gain[2] |-> ctrl.current_b_gain_log2 == AFE_LOG2_X32)
      else $error("channel B gain not x32 for code 100 up");

   a_gain_a_decode: assert property (
      s_write_hit and (req.addr == AFE_GAIN_ADDR && req.wdata[2:0] == 3'h3)
      |=> ctrl.current_a_gain_log2 == AFE_LOG2_X16)
      else $error("channel A code 011 not x16");

   a_bias_trim_write: assert property (
      s_write_hit and req.addr == AFE_BIAS_ADDR
      |=> {ctrl.second_stage_bias_trim, ctrl.first_stage_bias_trim} == $past(req.wdata[3:0]))
      else $error("bias trim fields not taken from write");

   a_amp_bias_write: assert property (
      s_write_hit and req.addr == AFE_MOD_ADDR
      |=> ctrl.voltage_amp_bias_select == $past(req.wdata[AFE_AMPBIAS_BIT]))
      else $error("amplifier bias bit not taken from write");

   a_clear_bit_holds: assert property (
      ctrl.current_a_integrator_clear && !bank_clr
      && !(req.wr && req.addr == AFE_MOD_ADDR)
      |=> ctrl.current_a_integrator_clear)
      else $error("integrator clear dropped without a write");

   a_clear_bit_set: assert property (
      s_write_hit and (req.addr == AFE_MOD_ADDR && req.wdata[3])
      |=> ctrl.spare_channel_integrator_clear [*1] ##0 ctrl.voltage_integrator_clear
          == $past(req.wdata[2]))
      else $error("integrator clear bits not mapped 3..0");

endmodule

// ==== tb/afe_ctrl_fe_model.sv ====
// Purpose: far-side model of the modulators that watch the control levels
// Assumes: the modulators sample the levels continuously, with no handshake
// Notes: reports which integrators are currently held in reset
`timescale 1ns/1ps
module afe_ctrl_fe_model
   import afe_ctrl_pkg::*;
(
   input wire logic ref_clk,
   input wire afe_ctrl_t ctrl,
   output logic [3:0] integ_held
);
   // an integrator stays cleared for as long as its level is high
   always_comb
   begin
      integ_held = {ctrl.spare_channel_integrator_clear, ctrl.voltage_integrator_clear,
         ctrl.current_b_integrator_clear, ctrl.current_a_integrator_clear};
   end
endmodule

// ==== tb/afe_ctrl_regs_test.sv ====
// Purpose: self-checking bench for the analog control register bank
// Assumes: one clock, strobes driven by non-blocking assignment at rising edges
// Notes: row table for plain accesses, hand tests for resets and decode
`timescale 1ns/1ps
module afe_ctrl_regs_test;
   import afe_ctrl_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic brownout_reset = 1'b0;
   logic external_reset_pin_n = 1'b1;
   logic watchdog_reset = 1'b0;
   afe_bus_req_t req = '0;
   logic [7:0] rd_data;
   afe_ctrl_t ctrl;
   logic [AFE_NUM_AUX-1:0][7:0] aux_regs;
   logic [3:0] held;
   int err_count = 0;
   int compares = 0;
   logic [7:0] got;
   // no row touches 0x2869 or 0x285f; reserved bits are written as zero
   logic [15:0] rows_a [10] = '{16'h2858, 16'h2858, 16'h2859, 16'h2859, 16'h285a,
      16'h285a, 16'h285b, 16'h2868, 16'h286b, 16'h2857};
   logic [7:0] rows_d [10] = '{8'h40, 8'h1c, 8'h0f, 8'h06, 8'h1f, 8'h00, 8'h12, 8'ha5,
      8'hff, 8'hff};
   logic [7:0] rows_e [10] = '{8'h40, 8'h1c, 8'h0f, 8'h06, 8'h1f, 8'h00, 8'h12, 8'ha5,
      8'h00, 8'h00};
   logic [2:0] log2_e [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5};

   always #4 ref_clk = ~ref_clk;

   afe_ctrl_regs afe_ctrl_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .brownout_reset(brownout_reset), .external_reset_pin_n(external_reset_pin_n),
      .watchdog_reset(watchdog_reset), .req(req), .rd_data(rd_data), .ctrl(ctrl),
      .aux_regs(aux_regs));
   afe_ctrl_fe_model afe_ctrl_fe_model_inst (.ref_clk(ref_clk), .ctrl(ctrl),
      .integ_held(held));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // level byte the front end sees for one address
   function automatic logic [7:0] lv(input logic [15:0] a);
      logic [15:0] d;
      d = a - 16'h285b;
      if (a == AFE_GAIN_ADDR)
         return {1'b0, ctrl.voltage_pga_gain, ctrl.current_b_pga_gain, ctrl.current_a_pga_gain};
      if (a == AFE_BIAS_ADDR)
         return {4'h0, ctrl.second_stage_bias_trim, ctrl.first_stage_bias_trim};
      if (a == AFE_MOD_ADDR)
         return {3'h0, ctrl.voltage_amp_bias_select, held};
      if (a > AFE_MOD_ADDR && a <= AFE_LAST_ADDR)
         return aux_regs[d[3:0]];
      return 8'h00;
   endfunction
   task automatic chk(input logic [7:0] exp, input logic [7:0] act);
      compares++;
      if (act !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      req <= '0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      req <= '0;
      #1;
      got = rd_data;
   endtask
   task automatic report_and_stop();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // watchdog: whole run needs well under 1000 cycles
   // ---------------------------------------------------------------
   initial
   begin
      #40000;
      err_count++;
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 17; i++)
      begin
         rd(AFE_BASE_ADDR + 16'(i));
         chk(AFE_REG_RESET, got);
      end
      for (int i = 0; i < 10; i++)
      begin
         wr(rows_a[i], rows_d[i]);
         chk(rows_e[i], lv(rows_a[i]));
         rd(rows_a[i]);
         chk(rows_e[i], got);
      end
      // write then read with no gap: the fresh byte must come straight back
      @(posedge ref_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: 16'h2864, wdata: 8'h5a};
      @(posedge ref_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: 16'h2864, wdata: 8'h00};
      @(posedge ref_clk);
      req <= '0;
      #1;
      chk(8'h5a, rd_data);
      // the second byte past the bank is read first and never written
      rd(16'h286a);
      chk(AFE_RD_UNMAPPED, got);
      // gain codes, both channels, saturating from 100
      for (int c = 0; c < 8; c++)
      begin
         wr(AFE_GAIN_ADDR, {2'b00, 3'(c), 3'(7 - c)});
         chk({5'h0, log2_e[c]}, {5'h0, ctrl.current_b_gain_log2});
         chk({5'h0, log2_e[7 - c]}, {5'h0, ctrl.current_a_gain_log2});
      end
      // bias codes
      for (int c = 0; c < 4; c++)
      begin
         wr(AFE_BIAS_ADDR, {4'h0, 2'(c), 2'(3 - c)});
         chk({4'h0, 2'(c), 2'(3 - c)}, lv(AFE_BIAS_ADDR));
      end
      // integrator clears hold without self-clearing
      wr(AFE_MOD_ADDR, 8'h1f);
      repeat (20) @(posedge ref_clk);
      chk(8'h1f, lv(AFE_MOD_ADDR));
      wr(AFE_MOD_ADDR, 8'h00);
      chk(8'h00, lv(AFE_MOD_ADDR));
      // each synchronous reset source; clear beats a same-cycle write
      for (int s = 0; s < 3; s++)
      begin
         wr(AFE_GAIN_ADDR, 8'h24);
         wr(16'h2868, 8'h3c);
         @(posedge ref_clk);
         req <= '{wr: 1'b1, rd: 1'b0, addr: AFE_BIAS_ADDR, wdata: 8'h0a};
         brownout_reset <= (s == 0);
         external_reset_pin_n <= (s != 1);
         watchdog_reset <= (s == 2);
         @(posedge ref_clk);
         req <= '0;
         brownout_reset <= 1'b0;
         external_reset_pin_n <= 1'b1;
         watchdog_reset <= 1'b0;
         #1;
         chk(8'h00, lv(AFE_GAIN_ADDR));
         chk(8'h00, lv(AFE_BIAS_ADDR));
         chk(8'h00, lv(16'h2868));
      end
      // asynchronous reset in mid-run; 0x285f stays at its default throughout
      wr(16'h2860, 8'h77);
      chk(8'h77, lv(16'h2860));
      @(posedge ref_clk);
      rst_n <= 1'b0;
      #1;
      chk(8'h00, lv(16'h2860));
      @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(16'h2860);
      chk(8'h00, got);
      report_and_stop();
   end
endmodule
